// >>> hdl/mtc_pkg.sv
// Constants, register map and encodings for the training command unit
package mtc_pkg;
   // Clock and timing, times in their own units
   localparam int CLK_PS      = 10000;
   localparam int ADR_NS      = 20;
   localparam int ADR_PS      = ADR_NS * 1000;
   localparam int MRZ_PS      = 1500;
   localparam int SPACE_NCK   = 2;
   // Longest time rounds down, least time rounds up, never below one
   localparam int ADR_CYC_RAW = ADR_PS / CLK_PS;
   localparam int ADR_CYC     = (ADR_CYC_RAW < 1) ? 1 : ADR_CYC_RAW;
   localparam int SPACE_CYC   = (ADR_PS + CLK_PS - 1) / CLK_PS + SPACE_NCK;
   localparam int MRZ_CYC_RAW = (MRZ_PS + CLK_PS - 1) / CLK_PS;
   localparam int MRZ_CYC     = (MRZ_CYC_RAW < 1) ? 1 : MRZ_CYC_RAW;
   localparam logic [3:0] ADR_CNT   = 4'(ADR_CYC);
   localparam logic [3:0] SPACE_CNT = 4'(SPACE_CYC);
   localparam logic [3:0] MRZ_CNT   = 4'(MRZ_CYC);

   // Command encodings on the first edge, ca[4:0]
   localparam logic [4:0] MPC_CODE  = 5'h00;
   localparam logic [4:0] CAS2_CODE = 5'h12;

   // Operand codes
   localparam logic [6:0] OP_RD_FIFO  = 7'h41;
   localparam logic [6:0] OP_RD_CAL   = 7'h43;
   localparam logic [6:0] OP_RFU      = 7'h45;
   localparam logic [6:0] OP_WR_FIFO  = 7'h47;
   localparam logic [6:0] OP_OSC_GO   = 7'h4B;
   localparam logic [6:0] OP_OSC_STOP = 7'h4D;
   localparam logic [6:0] OP_ZQ_START = 7'h4F;
   localparam logic [6:0] OP_ZQ_LATCH = 7'h51;
   localparam int         OP_TRAIN    = 6;

   // FIFO shape
   localparam int         FIFO_DEPTH = 5;
   localparam int         WORD_W     = 18;
   localparam logic [2:0] PTR_LAST   = 3'h4;
   localparam logic [2:0] PTR_FIRST  = 3'h0;

   // Latency pipeline
   localparam int LAT_DEPTH = 64;
   localparam int LAT_W     = 6;

   // Calibration read pattern, a plain default
   localparam logic [15:0] CAL_PATTERN = 16'h5AA5;

   // Register byte offsets
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_LAT    = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam logic [7:0] REG_ZQCNT  = 8'h0C;

   // Control fields
   localparam int CTRL_CBT_EN = 0;
   localparam int CTRL_WR_DBI = 1;
   localparam int CTRL_RD_DBI = 2;
   localparam int CTRL_DM_EN  = 3;
   localparam int CTRL_OPERATING_PARAMETER_SET = 4;
   localparam int CTRL_W      = 5;
   localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
   // Latency fields
   localparam int LAT_RL_LSB = 0;
   localparam int LAT_WL_LSB = 8;
   localparam logic [LAT_W-1:0] RL_RST = 6'h06;
   localparam logic [LAT_W-1:0] WL_RST = 6'h04;
   // Status fields
   localparam int ST_OSC    = 0;
   localparam int ST_FSP    = 2;
   localparam int ST_CBT    = 3;
   localparam int ST_SEQERR = 4;
   localparam int ST_WPTR   = 8;
   localparam int ST_RPTR   = 12;

   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic       HRESP_OKAY    = 1'b0;
endpackage

// >>> hdl/mtc_fifo.sv
// Five-entry training FIFO with wrapping write and read pointers
`timescale 1ns/1ns
module mtc_fifo
   import mtc_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              wr_en,
   input  wire logic [WORD_W-1:0] wr_data,
   input  wire logic              rd_en,
   output logic      [WORD_W-1:0] rd_data,
   output logic      [2:0]        wr_ptr,
   output logic      [2:0]        rd_ptr
);
   logic [WORD_W-1:0] mem_q [FIFO_DEPTH];
   logic [2:0]        wr_ptr_q;
   logic [2:0]        rd_ptr_q;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_ptr_q <= PTR_FIRST;
      end else if (wr_en) begin
         wr_ptr_q <= (wr_ptr_q == PTR_LAST) ? PTR_FIRST : wr_ptr_q + 3'h1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rd_ptr_q <= PTR_FIRST;
      end else if (rd_en) begin
         rd_ptr_q <= (rd_ptr_q == PTR_LAST) ? PTR_FIRST : rd_ptr_q + 3'h1;
      end
   end

   // storage has no reset, unwritten entries stay undefined
   for (genvar i = 0; i < FIFO_DEPTH; i++) begin : g_entry
      always_ff @(posedge clk) begin
         if (wr_en && wr_ptr_q == 3'(i)) begin
            mem_q[i] <= wr_data;
         end
      end
   end

   // Registered read word, a read never disturbs the stored entries
   always_ff @(posedge clk) begin
      if (rd_en) begin
         rd_data <= mem_q[rd_ptr_q];
      end
   end

   assign wr_ptr = wr_ptr_q;
   assign rd_ptr = rd_ptr_q;
endmodule

// >>> hdl/mtc_top.sv
// Multipurpose command decoder, training FIFO path and command bus training
//
// Implementation choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ns
module mtc_top
   import mtc_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic      [31:0] hrdata,
   // Command bus
   input  wire logic        cke,
   input  wire logic        cs,
   input  wire logic [5:0]  ca,
   // Data bus, one word per burst
   input  wire logic [15:0] dq_in,
   output logic      [15:0] dq_out,
   output logic             dq_oe,
   input  wire logic [1:0]  dmi_in,
   output logic      [1:0]  dmi_out,
   output logic             dmi_oe,
   // Function strobes and status levels
   output logic             osc_running,
   output logic             zq_start,
   output logic             zq_latch,
   output logic             fsp_active
);
   typedef enum logic [1:0] {
      MTC_NONE   = 2'b00,
      MTC_WR     = 2'b01,
      MTC_RD     = 2'b10,
      MTC_CAL    = 2'b11
   } mtc_op_e;

   logic [CTRL_W-1:0] ctrl_q;
   logic [LAT_W-1:0]  rl_q, wl_q;
   logic [7:0]        zq_go_cnt_q, zq_lat_cnt_q;
   logic              seq_err_q;
   logic              acc, wr_pend_q;
   logic [7:0]        addr_q;
   logic              cke_q, cbt_q;
   logic              mpc_half_q, op6_q;
   logic              cas_half_q;
   mtc_op_e           need_q, cas_op_q;
   logic [6:0]        op;
   logic              mpc_done, first_edge, cas_first, cas_done;
   logic              osc_q, zq_start_q, zq_latch_q;
   logic [LAT_DEPTH-1:0] wr_sr_q, rd_sr_q, cal_sr_q;
   logic              wr_tap, rd_tap, cal_tap;
   logic              rd_tap_q, cal_tap_q;
   logic [WORD_W-1:0] fifo_rd;
   logic [2:0]        wptr, rptr;
   logic              err_set, err_clr, mask_on;
   logic [5:0]        smp_q;
   logic [3:0]        adr_cnt_q, space_cnt_q, mrz_cnt_q;
   logic              smp_vld_q, cbt_drive_q;
   logic              cbt_sample;

   // Bus slave: zero wait states, always OKAY
   assign hreadyout = 1'b1;
   assign hresp     = HRESP_OKAY;
   assign acc       = hsel && hready && htrans == HTRANS_NONSEQ;

   // Address phase capture; all accesses are whole aligned words
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_pend_q <= 1'b0;
         addr_q    <= 8'h00;
      end else if (hready) begin
         wr_pend_q <= acc && hwrite;
         addr_q    <= acc ? haddr[7:0] : addr_q;
      end
   end

   // Control and latency registers, written in the data phase
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_q <= CTRL_RST;
         rl_q   <= RL_RST;
         wl_q   <= WL_RST;
      end else if (wr_pend_q) begin
         case (addr_q)
            REG_CTRL: begin
               ctrl_q <= hwdata[CTRL_W-1:0];
            end
            REG_LAT: begin
               rl_q <= hwdata[LAT_RL_LSB +: LAT_W];
               wl_q <= hwdata[LAT_WL_LSB +: LAT_W];
            end
            default: begin
            end
         endcase
      end
   end

   // Read mux over registered state; unmapped offsets read zero
   always_comb begin
      hrdata = 32'h0000_0000;
      case (addr_q)
         REG_CTRL: hrdata[CTRL_W-1:0] = ctrl_q;
         REG_LAT: begin
            hrdata[LAT_RL_LSB +: LAT_W] = rl_q;
            hrdata[LAT_WL_LSB +: LAT_W] = wl_q;
         end
         REG_STATUS: begin
            hrdata[ST_OSC]        = osc_q;
            hrdata[ST_FSP]        = fsp_active;
            hrdata[ST_CBT]        = cbt_q;
            hrdata[ST_SEQERR]     = seq_err_q;
            hrdata[ST_WPTR +: 3]  = wptr;
            hrdata[ST_RPTR +: 3]  = rptr;
         end
         REG_ZQCNT: hrdata[15:0] = {zq_lat_cnt_q, zq_go_cnt_q};
         default: hrdata = 32'h0000_0000;
      endcase
   end

   // Training mode tracks clock enable once software arms it
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cke_q <= 1'b0;
         cbt_q <= 1'b0;
      end else begin
         cke_q <= cke;
         if (cke) begin
            cbt_q <= 1'b0;
         end else if (cke_q && ctrl_q[CTRL_CBT_EN]) begin
            cbt_q <= 1'b1;
         end
      end
   end

   assign fsp_active = cbt_q ? ~ctrl_q[CTRL_OPERATING_PARAMETER_SET] : ctrl_q[CTRL_OPERATING_PARAMETER_SET];

   // Commands are decoded only while clock enable stays high, except the column command's second edge, which ignores it
   assign first_edge = cke && cke_q && cs && !mpc_half_q && !cas_half_q;
   assign cas_first  = first_edge && ca[4:0] == CAS2_CODE;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mpc_half_q <= 1'b0;
         op6_q      <= 1'b0;
      end else begin
         mpc_half_q <= first_edge && ca[4:0] == MPC_CODE;
         op6_q      <= first_edge ? ca[5] : op6_q;
      end
   end

   assign mpc_done = mpc_half_q && !cs && cke;
   assign op       = {op6_q, ca};

   function automatic mtc_op_e data_op(input logic [6:0] code);
      mtc_op_e r;
      r = MTC_NONE;
      if (code[OP_TRAIN]) begin
         case (code)
            OP_WR_FIFO: r = MTC_WR;
            OP_RD_FIFO: r = MTC_RD;
            OP_RD_CAL:  r = MTC_CAL;
            default:    r = MTC_NONE;
         endcase
      end
      return r;
   endfunction

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         osc_q        <= 1'b0;
         zq_start_q   <= 1'b0;
         zq_latch_q   <= 1'b0;
         zq_go_cnt_q  <= 8'h00;
         zq_lat_cnt_q <= 8'h00;
      end else begin
         zq_start_q <= 1'b0;
         zq_latch_q <= 1'b0;
         if (mpc_done) begin
            case (op)
               OP_OSC_GO:   osc_q <= 1'b1;
               OP_OSC_STOP: osc_q <= 1'b0;
               OP_ZQ_START: begin
                  zq_start_q  <= 1'b1;
                  zq_go_cnt_q <= zq_go_cnt_q + 8'h01;
               end
               OP_ZQ_LATCH: begin
                  zq_latch_q   <= 1'b1;
                  zq_lat_cnt_q <= zq_lat_cnt_q + 8'h01;
               end
               default: begin
               end
            endcase
         end
      end
   end

   assign osc_running = osc_q;
   assign zq_start    = zq_start_q;
   assign zq_latch    = zq_latch_q;

   // column command must come next; anything else drops the op
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         need_q     <= MTC_NONE;
         cas_half_q <= 1'b0;
         cas_op_q   <= MTC_NONE;
      end else begin
         cas_half_q <= cas_first && need_q != MTC_NONE;
         if (mpc_done) begin
            need_q <= data_op(op);
         end else if (first_edge) begin
            need_q <= MTC_NONE;
         end
         if (cas_first) begin
            cas_op_q <= need_q;
         end
      end
   end

   assign cas_done = cas_half_q && !cs;

   // nonzero operands flagged; missing column command flagged
   assign err_set = (first_edge && need_q != MTC_NONE && !cas_first)
                 || (cas_done && ca != 6'h00);
   assign err_clr = wr_pend_q && addr_q == REG_STATUS && hwdata[ST_SEQERR];

   // Sticky error; a new error in the clear cycle survives
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         seq_err_q <= 1'b0;
      end else if (err_set) begin
         seq_err_q <= 1'b1;
      end else if (err_clr) begin
         seq_err_q <= 1'b0;
      end
   end

   // latency starts at the second edge
   // pipelines let ops overlap at column spacing
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_sr_q  <= '0;
         rd_sr_q  <= '0;
         cal_sr_q <= '0;
      end else begin
         wr_sr_q  <= {wr_sr_q[LAT_DEPTH-2:0],  cas_done && cas_op_q == MTC_WR};
         rd_sr_q  <= {rd_sr_q[LAT_DEPTH-2:0],  cas_done && cas_op_q == MTC_RD};
         cal_sr_q <= {cal_sr_q[LAT_DEPTH-2:0], cas_done && cas_op_q == MTC_CAL};
      end
   end

   // no bank or refresh gating on writes
   assign wr_tap  = wr_sr_q[wl_q];
   assign rd_tap  = rd_sr_q[rl_q];
   assign cal_tap = cal_sr_q[rl_q];
   assign mask_on = ctrl_q[CTRL_WR_DBI] || ctrl_q[CTRL_RD_DBI]
                 || ctrl_q[CTRL_DM_EN];

   mtc_fifo u_fifo (
      .clk     (clk),
      .rst     (rst),
      .wr_en   (wr_tap),
      .wr_data ({dmi_in, dq_in}),
      .rd_en   (rd_tap),
      .rd_data (fifo_rd),
      .wr_ptr  (wptr),
      .rd_ptr  (rptr)
   );

   // FIFO word lands one cycle after the tap
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rd_tap_q  <= 1'b0;
         cal_tap_q <= 1'b0;
      end else begin
         rd_tap_q  <= rd_tap;
         cal_tap_q <= cal_tap;
      end
   end

   assign cbt_sample = cbt_q && !cke && cs;

   // newer sample replaces a withheld one and restarts timing
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         smp_q       <= 6'h00;
         smp_vld_q   <= 1'b0;
         adr_cnt_q   <= 4'h0;
         space_cnt_q <= 4'h0;
      end else if (cbt_sample) begin
         smp_q       <= ca;
         smp_vld_q   <= 1'b0;
         adr_cnt_q   <= ADR_CNT;
         space_cnt_q <= SPACE_CNT;
      end else begin
         if (adr_cnt_q != 4'h0) begin
            adr_cnt_q <= adr_cnt_q - 4'h1;
         end
         if (space_cnt_q != 4'h0) begin
            space_cnt_q <= space_cnt_q - 4'h1;
         end
         if (adr_cnt_q == 4'h1) begin
            smp_vld_q <= 1'b1;
         end
         if (!cbt_q) begin
            smp_vld_q <= 1'b0;
         end
      end
   end

   // outputs held a minimum time after exit
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cbt_drive_q <= 1'b0;
         mrz_cnt_q   <= 4'h0;
      end else if (cbt_q) begin
         cbt_drive_q <= 1'b1;
         mrz_cnt_q   <= MRZ_CNT;
      end else if (mrz_cnt_q != 4'h0) begin
         mrz_cnt_q <= mrz_cnt_q - 4'h1;
      end else begin
         cbt_drive_q <= 1'b0;
      end
   end

   // Data output flops; training drive takes priority over reads
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dq_out  <= 16'h0000;
         dq_oe   <= 1'b0;
         dmi_out <= 2'h0;
         dmi_oe  <= 1'b0;
      end else if (cbt_drive_q || cbt_q) begin
         dq_out  <= {10'h000, smp_vld_q ? smp_q : 6'h00};
         dq_oe   <= 1'b1;
         dmi_out <= 2'h0;
         dmi_oe  <= 1'b0;
      end else begin
         dq_oe   <= rd_tap_q || cal_tap_q;
         dq_out  <= cal_tap_q ? CAL_PATTERN : fifo_rd[15:0];
         dmi_oe  <= (rd_tap_q || cal_tap_q) && mask_on;
         dmi_out <= cal_tap_q ? 2'h0 : fifo_rd[17:16];
      end
   end

   // hsize is fixed at word transfers; unused bits tolerated
   logic unused_ok;
   assign unused_ok = ^{hsize, haddr[31:8], space_cnt_q};
endmodule

// >>> test/mtc_top_props.sv
// Port-level assertions for the training command unit
`timescale 1ns/1ns
module mtc_top_props
   import mtc_pkg::*;
(
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        cke,
   input wire logic        cs,
   input wire logic [5:0]  ca,
   input wire logic [15:0] dq_out,
   input wire logic        dq_oe,
   input wire logic        dmi_oe,
   input wire logic        osc_running,
   input wire logic        zq_start,
   input wire logic        zq_latch
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // Two-edge command; enable must also be high at the edge before
   sequence mpc_s(logic [6:0] op);
      cke ##1 (cke && cs && ca == {op[6], 5'h00}) ##1 (cke && !cs && ca == op[5:0]);
   endsequence
   // Lone training sample, no newer one to replace it
   sequence sample_s;
      (!cke && cs && dq_oe) ##1 (!cke && !cs) [*4];
   endsequence
   a_zq_start_pulse: assert property (mpc_s(OP_ZQ_START) |-> ##[1:2] zq_start)
      else $error("calibration start pulse missing");
   a_zq_latch_pulse: assert property (mpc_s(OP_ZQ_LATCH) |-> ##[1:2] zq_latch)
      else $error("calibration latch pulse missing");
   a_zq_single: assert property (zq_start |=> !zq_start)
      else $error("calibration start longer than one cycle");
   a_osc_go_seen: assert property (mpc_s(OP_OSC_GO) |-> ##[1:2] osc_running)
      else $error("oscillator did not start");
   a_osc_stop_seen: assert property (mpc_s(OP_OSC_STOP) |-> ##[1:2] !osc_running)
      else $error("oscillator did not stop");
   // low top bit means no operation
   a_nop_quiet: assert property (mpc_s(7'h0F) |=> !zq_start [*2])
      else $error("no-operation started calibration");
   // last sample echoed on data lines
   a_train_echo: assert property (sample_s |-> dq_out[5:0] == $past(ca, 4))
      else $error("training sample not echoed");
   a_train_release: assert property ($rose(cke) && dq_oe |=> dq_oe ##[1:4] !dq_oe)
      else $error("data outputs released too early or never");
   a_mask_with_data: assert property (dmi_oe |-> dq_oe)
      else $error("mask lines driven without data");
endmodule
bind mtc_top mtc_top_props mtc_top_props_inst (
   .clk(clk), .rst(rst), .cke(cke), .cs(cs), .ca(ca), .dq_out(dq_out), .dq_oe(dq_oe),
   .dmi_oe(dmi_oe), .osc_running(osc_running), .zq_start(zq_start), .zq_latch(zq_latch)
);

// >>> test/mtc_ctrl_model.sv
// Controller-side model driving the command bus and write data
`timescale 1ns/1ns
module mtc_ctrl_model
   import mtc_pkg::*;
(
   input  wire logic        clk,
   output logic             cke,
   output logic             cs,
   output logic      [5:0]  ca,
   output logic      [15:0] dq_in,
   output logic      [1:0]  dmi_in
);
   // Idle: enable high, deselected, data lines away from any stored word
   initial begin
      cke = 1'h1;
      cs = 1'h0;
      ca = 6'h00;
      dq_in = 16'hFFFF;
      dmi_in = 2'h3;
   end
   // One command word per rising edge
   task automatic cmd(input logic c, input logic [5:0] a);
      @(posedge clk);
      cs <= c;
      ca <= a;
   endtask
   // top bit first, lower bits second
   task automatic mpc(input logic [6:0] op);
      cmd(1'h1, {op[6], 5'h00});
      cmd(1'h0, op[5:0]);
   endtask
   // column command directly after, operands low
   task automatic cas2();
      cmd(1'h1, {1'h0, CAS2_CODE});
      cmd(1'h0, 6'h00);
   endtask
   // Word is valid for one edge only, then inverted so a late tap cannot match
   task automatic put_word(input int wl, input logic [17:0] w);
      repeat (wl + 1) @(posedge clk);
      {dmi_in, dq_in} <= w;
      @(posedge clk);
      {dmi_in, dq_in} <= ~w;
   endtask
   // lines low three cycles before any sample
   task automatic cbt_enter();
      @(posedge clk);
      cke <= 1'h0;
      repeat (3) cmd(1'h0, 6'h00);
   endtask
   // deselected two cycles before enable high
   task automatic cbt_exit();
      repeat (2) cmd(1'h0, 6'h00);
      @(posedge clk);
      cke <= 1'h1;
   endtask
endmodule

// >>> test/testbench.sv
// Self-checking bench for the training command unit
`timescale 1ns/1ns
module testbench
   import mtc_pkg::*;
;
   localparam int RL = 8;
   localparam int WL = 6;
   logic        clk, rst, hsel, hwrite, hreadyout, hresp;
   logic        cke, cs, dq_oe, dmi_oe, osc_running, zq_start, zq_latch, fsp_active;
   logic [31:0] haddr, hwdata, hrdata, rv;
   logic [1:0]  htrans, dmi_in, dmi_out;
   logic [2:0]  hsize;
   logic [5:0]  ca;
   logic [15:0] dq_in, dq_out;
   logic [6:0]  ops [4];
   int          errors, checks;

   mtc_top mtc_top_inst (
      .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .cke(cke), .cs(cs), .ca(ca), .dq_in(dq_in),
      .dq_out(dq_out), .dq_oe(dq_oe), .dmi_in(dmi_in), .dmi_out(dmi_out), .dmi_oe(dmi_oe),
      .osc_running(osc_running), .zq_start(zq_start), .zq_latch(zq_latch),
      .fsp_active(fsp_active)
   );
   mtc_ctrl_model mtc_ctrl_model_inst (
      .clk(clk), .cke(cke), .cs(cs), .ca(ca), .dq_in(dq_in), .dmi_in(dmi_in)
   );

   // Free-running 100 MHz clock
   initial begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end

   task automatic check(input string n, input logic [31:0] seen, input logic [31:0] e);
      checks++;
      if (seen !== e) begin
         errors++;
         $display("mismatch %s expected %h seen %h", n, e, seen);
      end
   endtask
   // Single word transfer; read data taken at the edge closing the data phase
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'h1;
      haddr <= {24'h000000, a};
      htrans <= HTRANS_NONSEQ;
      hwrite <= w;
      do @(posedge clk); while (hreadyout !== 1'h1);
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'h1);
      rv = hrdata;
   endtask
   task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
      ahb(1'h0, a, 32'h00000000);
      check(n, rv, e);
   endtask
   function automatic logic [17:0] wd(input int i);
      return {i[1:0], 16'hC3A0 + 16'(i)};
   endfunction
   // Data shows after edge RL+2 past the column command's second edge, for one cycle
   task automatic rd_word(input logic [6:0] op, input logic [17:0] w);
      mtc_ctrl_model_inst.mpc(op);
      mtc_ctrl_model_inst.cas2();
      repeat (RL + 3) @(posedge clk);
      #1;
      check("read word", {12'h000, dmi_oe, dq_oe, dmi_out, dq_out}, {14'h0003, w});
   endtask
   task automatic report_and_stop();
      if (errors == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // A few thousand cycles cover the whole sequence with margin
   initial begin
      repeat (5000) @(posedge clk);
      errors++;
      report_and_stop();
   end

   initial begin
      {hsel, hwrite, haddr, htrans, hwdata, errors, checks} = '0;
      rst = 1'h1;
      hsize = 3'h2;
      repeat (5) @(posedge clk);
      rst <= 1'h0;
      // Latencies moved off their reset values, masking enabled
      ahb(1'h1, REG_LAT, 32'h00000608);
      ahb(1'h1, REG_CTRL, 32'h00000008);
      rchk("latency", REG_LAT, 32'h00000608);
      rchk("hole", 8'h10, 32'h00000000);
      // Six writes: the last lands on the first entry
      for (int i = 0; i < 6; i++) begin
         mtc_ctrl_model_inst.mpc(OP_WR_FIFO);
         mtc_ctrl_model_inst.cas2();
         mtc_ctrl_model_inst.put_word(WL, wd(i));
      end
      rchk("pointers", REG_STATUS, 32'h00000100);
      // reads follow writes, no command between
      for (int j = 0; j < 6; j++) rd_word(OP_RD_FIFO, wd((j % 5 == 0) ? 5 : j));
      rchk("pointers", REG_STATUS, 32'h00001100);
      repeat (20) @(posedge clk);
      rd_word(OP_RD_CAL, {2'h0, CAL_PATTERN});
      // Reserved codes and no-operations leave all state alone
      ops = '{OP_RFU, 7'h49, 7'h07, 7'h0F};
      foreach (ops[k]) mtc_ctrl_model_inst.mpc(ops[k]);
      repeat (3) @(posedge clk);
      rchk("reserved", REG_STATUS, 32'h00001100);
      rchk("zq count", REG_ZQCNT, 32'h00000000);
      ops = '{OP_OSC_GO, OP_ZQ_START, OP_ZQ_LATCH, OP_OSC_STOP};
      foreach (ops[k]) begin
         mtc_ctrl_model_inst.mpc(ops[k]);
         repeat (3) @(posedge clk);
         check("oscillator", 32'(osc_running), {31'h0, k != 3});
      end
      rchk("zq count", REG_ZQCNT, 32'h00000101);
      // Column command missing after a data function
      mtc_ctrl_model_inst.mpc(OP_WR_FIFO);
      mtc_ctrl_model_inst.mpc(7'h00);
      repeat (3) @(posedge clk);
      rchk("sequence flag", REG_STATUS, 32'h00001110);
      ahb(1'h1, REG_STATUS, 32'h00000010);
      rchk("flag cleared", REG_STATUS, 32'h00001100);
      // Bus training: two close samples, only the last is echoed
      ahb(1'h1, REG_CTRL, 32'h00000009);
      mtc_ctrl_model_inst.cbt_enter();
      check("fsp entry", 32'(fsp_active), 32'h00000001);
      mtc_ctrl_model_inst.cmd(1'h1, 6'h11);
      mtc_ctrl_model_inst.cmd(1'h1, 6'h2D);
      mtc_ctrl_model_inst.cmd(1'h0, 6'h00);
      repeat (3) @(posedge clk);
      #1;
      check("echo", {25'h0, dq_oe, dq_out[5:0]}, 32'h0000006D);
      check("upper valid", 32'(^dq_out[15:14] !== 1'bx), 32'h00000001);
      mtc_ctrl_model_inst.cbt_exit();
      @(posedge clk);
      #1;
      check("exit", {30'h0, dq_oe, fsp_active}, 32'h00000002);
      repeat (4) @(posedge clk);
      #1;
      check("released", 32'(dq_oe), 32'h00000000);
      report_and_stop();
   end
endmodule
